// ==== shared/flash_consts.svh ====
/*
  Constants for the flash block-erase and protection controller.
  Assumes byte addressing of the array and a single system clock.
*/
// Function
// - Array holds 96 KB; every address in that range is decoded.
// - Erase works per 1-KB block, leaving other blocks untouched.
// - A finished erase leaves every bit of the block at one.
// - Protection covers 2-KB units of two blocks, each set independently.
// - Each unit is open, read-only or execute-only.
// - Read-only units refuse erase and program; contents stay unchanged.
// - Execute-only units refuse erase and program too.
// - Execute-only units answer instruction fetch only; data and debug reads denied.
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

`define FLASH_BYTES      98304
`define FLASH_ADDR_W     17
`define FLASH_WORDS      24576
`define FLASH_WORD_AW    15
`define BLOCK_WORD_BITS  8
`define BLOCK_COUNT      96
`define UNIT_WORD_BITS   9
`define UNIT_COUNT       48
`define UNIT_IDX_W       6
`define ERASED_WORD      32'hFFFFFFFF

`endif

// ==== shared/flash_pkg.sv ====
/*
  Types for the flash controller.
  Assumes flash_consts.svh is on the include path.
*/
`include "flash_consts.svh"
package flash_pkg;

  typedef enum logic [1:0] {
    prot_open,
    prot_read_only,
    prot_exec_only
  } prot_type;

  typedef enum logic [2:0] {
    op_none,
    op_fetch,
    op_data_read,
    op_debug_read,
    op_program,
    op_erase
  } op_type;

  typedef struct packed {
    op_type                    op;
    logic [`FLASH_ADDR_W-1:0]  addr;
    logic [31:0]               wdata;
  } request_type;

  typedef struct packed {
    logic        valid;
    logic        denied;
    logic [31:0] rdata;
  } answer_type;

endpackage

// ==== verilog/prot_check.sv ====
/*
  Protection check: decides whether one request may touch the array.
  Assumes an in-range flag for the address and the unit's protection mode as input.
*/
`timescale 1ns/1ps
module prot_check
  import flash_pkg::*;
(
  input  wire op_type   op,
  input  wire prot_type mode,
  input  wire logic     in_range,
  output logic          allow
);

  always_comb begin
    allow = 1'b0;
    if (in_range) begin
      unique case (mode)
        prot_open:      allow = (op != op_none);
        prot_read_only: allow = (op == op_fetch) || (op == op_data_read)
                              || (op == op_debug_read);
        prot_exec_only: allow = (op == op_fetch);
        default:        allow = 1'b0;
      endcase
    end
  end

endmodule

// ==== verilog/flash_block_erase_protect.sv ====
/*
  Flash array controller: word read, program and 1-KB block erase, with
  per-2-KB-unit protection. Requests come one per cycle from an arbiter
  over fetch, data and debug paths; protection modes come from an outside
  configuration port. Single clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "flash_consts.svh"
module flash_block_erase_protect
  import flash_pkg::*;
#(
  parameter int WORD_AW = `FLASH_WORD_AW,
  parameter int WORDS   = `FLASH_WORDS
)(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire request_type            req,
  input  wire logic                   cfg_write,
  input  wire logic [`UNIT_IDX_W-1:0] cfg_unit,
  input  wire prot_type               cfg_mode,
  input  wire logic                   violation_clear,
  output answer_type                  answer,
  output logic                        busy,
  output logic                        violation,
  output logic                        range_error
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] array [WORDS];
  prot_type    unit_mode [`UNIT_COUNT];

  typedef enum {idle, erasing} state_type;
  state_type state;
  logic [`BLOCK_WORD_BITS-1:0] erase_count;
  logic [WORD_AW-`BLOCK_WORD_BITS-1:0] erase_block;

  function automatic logic [WORD_AW-1:0] word_of(input logic [`FLASH_ADDR_W-1:0] a);
    word_of = a[`FLASH_ADDR_W-1:2];
  endfunction

  // All three read paths return array contents when granted
  function automatic logic is_read(input op_type op);
    is_read = (op == op_fetch) || (op == op_data_read) || (op == op_debug_read);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [WORD_AW-1:0]       word_addr;
  logic                     in_range;
  logic [`UNIT_IDX_W-1:0]   unit_idx;
  logic                     allow;
  logic                     take;

  assign word_addr = word_of(req.addr);
  assign in_range  = (word_addr < WORD_AW'(WORDS));
  assign unit_idx  = in_range ? `UNIT_IDX_W'(word_addr >> `UNIT_WORD_BITS)
                              : '0;
  assign take      = (state == idle) && (req.op != op_none);

  prot_check u_check (
    .op       (req.op),
    .mode     (unit_mode[unit_idx]),
    .in_range (in_range),
    .allow    (allow)
  );

  // ----------------------------------------------------------------
  // Request qualification
  // ----------------------------------------------------------------
  // Requests met during an erase are dropped unanswered,
  // so every qualifier below is gated by take
  logic                     erase_go;
  logic                     program_go;
  logic                     read_go;
  logic                     protect_hit;
  logic                     range_miss;
  logic                     erase_last;
  logic [WORD_AW-1:0]       erase_word;

  // Out-of-range requests raise range_error, not the protection flag
  assign erase_go    = take && allow && (req.op == op_erase);
  assign program_go  = take && allow && (req.op == op_program);
  assign read_go     = take && allow && is_read(req.op);
  assign protect_hit = take && in_range && !allow;
  assign range_miss  = take && !in_range;
  assign erase_last  = &erase_count;
  assign erase_word  = {erase_block, erase_count};

  // ----------------------------------------------------------------
  // Protection configuration
  // ----------------------------------------------------------------
  // Unit numbers past the last unit are dropped, never wrapped onto a real one
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `UNIT_COUNT; i++) begin
        unit_mode[i] <= prot_open;
      end
    end else if (cfg_write && (cfg_unit < `UNIT_IDX_W'(`UNIT_COUNT))) begin
      unit_mode[cfg_unit] <= cfg_mode;
    end
  end

  // ----------------------------------------------------------------
  // Erase sequencer, one word per cycle
  // ----------------------------------------------------------------
  // Nothing is taken while erasing, so the count never restarts mid-block
  always_ff @(posedge clock) begin
    if (rst) begin
      state       <= idle;
      erase_count <= '0;
      erase_block <= '0;
    end else begin
      unique case (state)
        idle: begin
          if (erase_go) begin
            state       <= erasing;
            erase_block <= word_addr[WORD_AW-1:`BLOCK_WORD_BITS];
            erase_count <= '0;
          end
        end
        erasing: begin
          erase_count <= erase_count + 1'b1;
          if (erase_last) begin
            state <= idle;
          end
        end
      endcase
    end
  end

  // Busy rides on a flop of its own so the output needs no decode of state
  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (erase_go) begin
      busy <= 1'b1;
    end else if ((state == erasing) && erase_last) begin
      busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Array writes: no reset, contents survive reset like real flash
  // ----------------------------------------------------------------
  // A reset in mid-erase leaves the block part erased; erase it again
  always_ff @(posedge clock) begin
    if (state == erasing) begin
      array[erase_word] <= `ERASED_WORD;
    end else if (program_go) begin
      // Programming can only clear bits, as in a real cell
      array[word_addr] <= array[word_addr] & req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Answers
  // ----------------------------------------------------------------
  logic        answer_valid;
  logic        answer_denied;
  logic [31:0] answer_rdata;

  // Valid pulses once per taken request, granted or refused
  always_ff @(posedge clock) begin
    if (rst) begin
      answer_valid <= 1'b0;
    end else begin
      answer_valid <= take;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      answer_denied <= 1'b0;
    end else begin
      answer_denied <= take && !allow;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Denied reads and all writes answer zero, so nothing leaks from a guarded unit
  always_ff @(posedge clock) begin
    if (rst) begin
      answer_rdata <= '0;
    end else if (read_go) begin
      answer_rdata <= array[word_addr];
    end else begin
      answer_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Answer assembly
  // ----------------------------------------------------------------
  assign answer = '{valid: answer_valid, denied: answer_denied, rdata: answer_rdata};

  // ----------------------------------------------------------------
  // Status flags; a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      violation <= 1'b0;
    end else if (protect_hit) begin
      violation <= 1'b1;
    end else if (violation_clear) begin
      violation <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      range_error <= 1'b0;
    end else if (range_miss) begin
      range_error <= 1'b1;
    end else if (violation_clear) begin
      range_error <= 1'b0;
    end
  end

endmodule

// ==== verification/flash_block_erase_protect_properties.sv ====
/* Port checker for the flash controller.
   Assumes it is bound to flash_block_erase_protect. */
`timescale 1ns/1ps
module flash_block_erase_protect_properties
  import flash_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire request_type req,
  input wire logic        violation_clear,
  input wire answer_type  answer,
  input wire logic        busy,
  input wire logic        violation,
  input wire logic        range_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic taken = !busy && req.op != op_none;
  a_answer_due: assert property (taken |=> answer.valid)
    else $error("no answer");
  a_no_stray: assert property (!taken |=> !answer.valid)
    else $error("stray answer");
  a_range_denied: assert property (taken && req.addr >= 17'h18000 |=> answer.denied && range_error)
    else $error("range");
  a_erase_start: assert property (taken && req.op == op_erase |=> busy || answer.denied)
    else $error("erase start");
  a_erase_length: assert property ($rose(busy) |-> ##255 busy ##1 !busy)
    else $error("erase length");
  a_denied_flag: assert property (answer.denied |-> violation || range_error)
    else $error("unflagged");
  a_denied_blank: assert property (answer.denied |-> answer.rdata == 32'h0)
    else $error("data leak");
  a_flag_sticky: assert property (violation && !violation_clear |=> violation)
    else $error("flag lost");
  c_erase: cover property ($rose(busy));
  c_denied: cover property (answer.denied);
  c_range: cover property ($rose(range_error));
endmodule
bind flash_block_erase_protect flash_block_erase_protect_properties props_u (.clock(clock), .rst(rst), .req(req),
  .violation_clear(violation_clear), .answer(answer), .busy(busy), .violation(violation), .range_error(range_error));

// ==== verification/flash_master.sv ====
/* Request model of the fetch, data and debug paths.
   Assumes start and cmd change on falling edges. */
`timescale 1ns/1ps
module flash_master
  import flash_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        start,
  input  wire request_type cmd,
  input  wire answer_type  answer,
  output request_type      req = '0,
  output answer_type       got = '0,
  output logic             done = 1'h0
);
  // Idle lines show inverted leftovers, never the old request
  always @(negedge clock) req <= start ? cmd : request_type'{op_none, ~req.addr, ~req.wdata};
  always @(posedge clock) done <= !start && (done || answer.valid);
  always @(posedge clock) if (answer.valid) got <= answer;
endmodule

// ==== verification/tb.sv ====
/* Self-checking bench for the flash controller.
   Assumes the checker is bound and the request model is compiled. */
`timescale 1ns/1ps
module tb
  import flash_pkg::*;
;
  localparam logic [31:0] ones = 32'hFFFFFFFF;
  localparam logic [31:0] pat  = 32'h12345678;
  logic        clock = 1'h0, rst = 1'h1, start = 1'h0, cfg_write = 1'h0, violation_clear = 1'h0;
  prot_type    cfg_mode = prot_open;
  logic [5:0]  cfg_unit = 6'h00;
  request_type cmd = '0, req;
  answer_type  answer, got;
  logic        busy, violation, range_error, done;
  int          fails = 0, check_count = 0;
  flash_block_erase_protect dut_u (.clock(clock), .rst(rst), .req(req), .cfg_write(cfg_write), .cfg_unit(cfg_unit),
    .cfg_mode(cfg_mode), .violation_clear(violation_clear), .answer(answer), .busy(busy), .violation(violation),
    .range_error(range_error));
  flash_master partner_u (.clock(clock), .start(start), .cmd(cmd), .answer(answer), .req(req), .got(got), .done(done));
  initial forever #5 clock = ~clock;
  task automatic report_and_stop;
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Erase steps wait out busy before returning
  task automatic go(input op_type op, input logic [16:0] addr, input logic den, input logic [31:0] rd,
                    input logic [31:0] wdata = '0);
    int n;
    cmd <= '{op, addr, wdata};
    start <= 1'h1;
    @(negedge clock) start <= 1'h0;
    for (n = 0; n < 300 && !(done === 1'h1 && busy === 1'h0); n++) @(negedge clock);
    if (n == 300) begin
      fails++;
      report_and_stop;
    end
    check("denied", got.denied, den);
    check("rdata", got.rdata, rd);
  endtask
  task automatic set_mode(input logic [5:0] unit, input prot_type mode);
    cfg_unit = unit;
    cfg_mode = mode;
    cfg_write = 1'h1;
    @(negedge clock) cfg_write = 1'h0;
  endtask
  task automatic open_units;
    go(op_erase, 17'h00400, 1'h0, '0);
    go(op_debug_read, 17'h007FC, 1'h0, ones);
    go(op_program, 17'h00400, 1'h0, '0, pat);
    go(op_erase, 17'h00000, 1'h0, '0);
    go(op_fetch, 17'h00400, 1'h0, pat);
  endtask
  task automatic protected_units;
    set_mode(6'h00, prot_read_only);
    go(op_program, 17'h00400, 1'h1, '0);
    go(op_erase, 17'h00000, 1'h1, '0);
    go(op_data_read, 17'h00400, 1'h0, pat);
    check("flag", violation, 32'h1);
    violation_clear = 1'h1;
    @(negedge clock) violation_clear = 1'h0;
    check("flag", violation, 32'h0);
    set_mode(6'h00, prot_exec_only);
    go(op_fetch, 17'h00400, 1'h0, pat);
    go(op_data_read, 17'h00400, 1'h1, '0);
    go(op_debug_read, 17'h00400, 1'h1, '0);
    go(op_program, 17'h00400, 1'h1, '0);
    go(op_erase, 17'h00000, 1'h1, '0);
    go(op_erase, 17'h00800, 1'h0, '0);
    go(op_data_read, 17'h00BFC, 1'h0, ones);
  endtask
  task automatic range_edge;
    go(op_erase, 17'h17C00, 1'h0, '0);
    go(op_data_read, 17'h17FFC, 1'h0, ones);
    set_mode(6'h2F, prot_read_only);
    go(op_program, 17'h17FFC, 1'h1, '0);
    go(op_fetch, 17'h17FFC, 1'h0, ones);
    go(op_fetch, 17'h18000, 1'h1, '0);
    check("range", range_error, 32'h1);
    violation_clear = 1'h1;
    @(negedge clock) violation_clear = 1'h0;
    check("range", range_error, 32'h0);
  endtask
  // Reset in mid-run reopens every unit but keeps the array contents
  task automatic reset_reopens;
    go(op_data_read, 17'h00400, 1'h1, '0);
    rst = 1'h1;
    repeat (2) @(negedge clock);
    rst = 1'h0;
    check("flag", violation, 32'h0);
    go(op_data_read, 17'h00400, 1'h0, pat);
    go(op_program, 17'h17FFC, 1'h0, '0, 32'h0000FFFF);
    go(op_debug_read, 17'h17FFC, 1'h0, 32'h0000FFFF);
  endtask
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'h0;
    open_units;
    protected_units;
    range_edge;
    reset_reopens;
    report_and_stop;
  end
endmodule
